// ==== hdl/ieu_arb.sv ====
// priority resolver for maskable sources
module ieu_arb #(
  parameter bit TIE_ASCEND = 1'b1
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  // pending requests and their levels
  input  wire logic [ieu_pkg::NSRC-1:0]   req,
  input  wire logic [ieu_pkg::NSRC-1:0]   rise,
  input  wire ieu_pkg::ieu_lvl_type       lvl [ieu_pkg::NSRC],
  // winner
  output logic                            win_v,
  output logic [ieu_pkg::IDXW-1:0]        win_i,
  output ieu_pkg::ieu_lvl_type            win_l
);
  import ieu_pkg::*;

  logic [AGEW-1:0] cnt_ff;
  logic [AGEW-1:0] stamp_ff [NSRC];
  logic [AGEW-1:0] best_age;

  // arrival stamps give age among equal levels
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cnt_ff <= '0;
    else if (|rise) cnt_ff <= cnt_ff + 8'h01;
  end

  for (genvar g = 0; g < NSRC; g++) begin : g_stamp
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) stamp_ff[g] <= '0;
      else if (rise[g]) stamp_ff[g] <= cnt_ff;
    end
  end

  always_comb begin
    int i;
    logic [AGEW-1:0] age;
    i = 0;
    age = '0;
    win_v = 1'b0;
    win_i = '0;
    win_l = '0;
    best_age = '0;
    for (int k = 0; k < NSRC; k++) begin
      i = TIE_ASCEND ? k : NSRC - 1 - k;
      age = cnt_ff - stamp_ff[i];
      // strict compare keeps the first index scanned (lowest if TIE_ASCEND, else highest) on a full tie
      if (req[i] && (!win_v || lvl[i] > win_l ||
          (lvl[i] == win_l && age > best_age))) begin
        win_v = 1'b1;
        win_i = IDXW'(i);
        win_l = lvl[i];
        best_age = age;
      end
    end
  end
endmodule : ieu_arb

// ==== hdl/ieu_pkg.sv ====
// constants and types of the interrupt entry unit
package ieu_pkg;
  localparam int NSRC = 8;
  localparam int IDXW = 3;
  localparam int AW   = 24;
  localparam int AGEW = 8;
  // register offsets
  localparam logic [7:0] A_VBASE = 8'h00;
  localparam logic [7:0] A_FLAGS = 8'h04;
  localparam logic [7:0] A_IPL   = 8'h08;
  localparam logic [7:0] A_ISTK  = 8'h0C;
  localparam logic [7:0] A_USTK  = 8'h10;
  localparam logic [7:0] A_SVF   = 8'h14;
  localparam logic [7:0] A_SVPC  = 8'h18;
  localparam logic [7:0] A_STAT  = 8'h1C;
  localparam logic [7:0] A_FAST  = 8'h20;
  localparam logic [7:0] A_SRC0  = 8'h40;
  localparam logic [7:0] A_SRCN  = 8'h60;
  // field positions
  localparam int F_I = 0;
  localparam int F_D = 1;
  localparam int F_U = 2;
  localparam int FLGW = 3;
  localparam int CTL_REQ = 3;
  localparam int FAST_EN = 3;
  localparam int INFO_LVL_LSB = 8;
  // vector table
  localparam int VEC_TABLE_BYTES = 256;
  localparam int VEC_BYTES = 4;
  localparam int VEC_COUNT = VEC_TABLE_BYTES / VEC_BYTES;
  localparam logic [23:0] INFO_ADDR      = 24'h00_0000;
  localparam logic [23:0] FAST_INFO_ADDR = 24'h00_0002;
  localparam logic [23:0] WDT_VEC_ADDR   = 24'hFF_FFDC;
  localparam logic [5:0]  SRC_NUM_BASE   = 6'h08;
  localparam logic [5:0]  TRAP_KEEP_U    = 6'h20;
  localparam logic [2:0]  NMI_LEVEL      = 3'h7;
  localparam logic [23:0] STK_RST        = 24'h00_0000;
  localparam logic [2:0]  FLAGS_RST      = 3'h0;
  typedef logic [2:0] ieu_lvl_type;
  typedef enum logic [2:0] {
    S_IDLE, S_INFO, S_SAVE, S_PUSH_F, S_PUSH_PC, S_VEC, S_IPL, S_GO
  } ieu_state_type;
  typedef enum logic [1:0] {K_MASK, K_NMI, K_TRAP} ieu_kind_type;
endpackage : ieu_pkg

// ==== hdl/ieu_sync.sv ====
// two-flop synchroniser for request pins
module ieu_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // pins and synchronised levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule : ieu_sync

// ==== hdl/ieu_top.sv ====
// interrupt acceptance and entry sequencer with apb registers
// Functional notes
// - vector table is 256 bytes at base
// - four-byte entries, numbers 0 to 63
// - trap number dispatches through its vector
// - accept needs enable, higher level, request bit
// - request bit cleared by writing zero or by the info read at entry
// - ordinary instruction: resolve at end, enter next
// - string and sum-of-products ops are suspended
// - read info word, then clear request
// - flags captured in a temporary register
// - clear enable, debug flags; stack-select also cleared except for traps 32 and up
// - push flags and pc, fast uses saves
// - priority level loaded last
// - fetch resumes at routine start address
// - only highest simultaneous request accepted
// - level fields, then age, then fixed order
// - watchdog non-maskable, reset above all
// - traps skip masking and arbitration
module ieu_top #(
  parameter bit TIE_ASCEND = 1'b1
) (
  // clock and reset
  input  wire logic                     CLK_SYS,
  input  wire logic                     RST_B,
  // apb slave
  input  wire logic                     PSEL,
  input  wire logic                     PENABLE,
  input  wire logic                     PWRITE,
  input  wire logic [7:0]               PADDR,
  input  wire logic [31:0]              PWDATA,
  output logic      [31:0]              PRDATA,
  output logic                          PREADY,
  output logic                          PSLVERR,
  // request sources
  input  wire logic [ieu_pkg::NSRC-1:0] IRQ_IN,
  input  wire logic                     WDT_IN,
  // instruction sequencer
  input  wire logic                     INSTR_DONE,
  input  wire logic                     INSTR_BREAKABLE,
  input  wire logic                     TRAP_REQ,
  input  wire logic [5:0]               TRAP_NUM,
  input  wire logic [ieu_pkg::AW-1:0]   PROGRAM_COUNTER,
  output logic                          ENTRY_BUSY,
  output logic                          SUSPEND,
  output logic                          FETCH_GO,
  output logic      [ieu_pkg::AW-1:0]   FETCH_ADDR,
  output logic      [ieu_pkg::FLGW-1:0] CPU_FLAGS,
  output logic      [2:0]               CPU_IPL,
  // memory port
  output logic                          MEM_REQ,
  output logic                          MEM_WE,
  output logic      [ieu_pkg::AW-1:0]   MEM_ADDR,
  output logic      [31:0]              MEM_WDATA,
  input  wire logic                     MEM_ACK,
  input  wire logic [31:0]              MEM_RDATA
);
  import ieu_pkg::*;

  function automatic logic src_hit(input logic [7:0] a);
    return a >= A_SRC0 && a < A_SRCN && a[1:0] == 2'h0;
  endfunction : src_hit

  function automatic logic [IDXW-1:0] src_idx(input logic [7:0] a);
    return a[IDXW+1:2];
  endfunction : src_idx

  ieu_state_type   state_ff, nxt_state;
  ieu_kind_type    kind_ff, nxt_kind;
  logic [5:0]      num_ff, nxt_num;
  ieu_lvl_type     lvl_acc_ff, nxt_lvl_acc;
  logic            fast_ff, nxt_fast;
  logic [IDXW-1:0] widx_ff, nxt_widx;
  logic [AW-1:0]   pc_ff, nxt_pc;
  logic [FLGW-1:0] tmp_flags_ff, nxt_tmp_flags;
  logic [FLGW-1:0] cpu_flags_reg_ff, nxt_cpu_flags_reg;
  ieu_lvl_type     cpu_priority_level_ff, nxt_cpu_priority_level;
  logic [AW-1:0]   vector_base_reg_ff, nxt_vector_base_reg;
  logic [AW-1:0]   irq_stack_ptr_ff, nxt_irq_stack_ptr;
  logic [AW-1:0]   user_stack_ptr_ff, nxt_user_stack_ptr;
  logic [FLGW-1:0] fast_flags_save_ff, nxt_fast_flags_save;
  logic [AW-1:0]   fast_pc_save_ff, nxt_fast_pc_save;
  logic [AW-1:0]   vec_ff, nxt_vec;
  logic [3:0]      fast_ctl_ff, nxt_fast_ctl;
  logic            wdt_pend_ff;
  logic [NSRC-1:0] irq_s, irq_prev_ff, irq_rise;
  logic [NSRC-1:0] req_ff, src_clr;
  ieu_lvl_type     lvl_ff [NSRC];
  logic            win_v, clr_req, rd_ok;
  logic [IDXW-1:0] win_i;
  ieu_lvl_type     win_l;
  logic [31:0]     rd_data, mem_wdata;
  logic [AW-1:0]   mem_addr;

  // apb: one wait state, write and read data at the ready edge
  wire apb_set  = PSEL & PENABLE & ~PREADY;
  wire apb_wr   = PSEL & PENABLE & PREADY & PWRITE;
  wire wr_src   = apb_wr & src_hit(PADDR);
  wire idle     = state_ff == S_IDLE;
  wire mem_done = MEM_REQ & MEM_ACK;
  wire [AW-1:0] sp_cur = cpu_flags_reg_ff[F_U] ? user_stack_ptr_ff
                                              : irq_stack_ptr_ff;
  wire [AW-1:0] vec_addr = vector_base_reg_ff + {16'h0000, num_ff, 2'h0};

  // acceptance points and gates
  wire at_point  = INSTR_DONE | INSTR_BREAKABLE;
  wire mask_ok   = cpu_flags_reg_ff[F_I] & win_v &
                   (cpu_priority_level_ff < win_l);
  wire take_trap = idle & TRAP_REQ;
  wire take_nmi  = idle & ~TRAP_REQ & wdt_pend_ff & at_point;
  wire take_mask = idle & ~TRAP_REQ & ~wdt_pend_ff & at_point & mask_ok;
  wire take      = take_trap | take_nmi | take_mask;
  wire is_fast   = fast_ctl_ff[FAST_EN] & (fast_ctl_ff[2:0] == win_i);
  wire keep_u    = kind_ff == K_TRAP && num_ff >= TRAP_KEEP_U;
  wire mem_need  = state_ff == S_INFO || state_ff == S_PUSH_F ||
                   state_ff == S_PUSH_PC || state_ff == S_VEC;
  wire mem_we    = state_ff == S_PUSH_F || state_ff == S_PUSH_PC;

  ieu_sync #(.W(NSRC)) u_sync (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .d     (IRQ_IN),
    .q     (irq_s)
  );

  assign irq_rise = irq_s & ~irq_prev_ff;

  ieu_arb #(.TIE_ASCEND(TIE_ASCEND)) u_arb (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .req   (req_ff),
    .rise  (irq_rise),
    .lvl   (lvl_ff),
    .win_v (win_v),
    .win_i (win_i),
    .win_l (win_l)
  );

  // per-source control: level field and request bit
  for (genvar g = 0; g < NSRC; g++) begin : g_src
    wire hit = wr_src && src_idx(PADDR) == IDXW'(g);
    assign src_clr[g] = (hit && !PWDATA[CTL_REQ]) ||
                        (clr_req && widx_ff == IDXW'(g));
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
        req_ff[g] <= 1'b0;
        lvl_ff[g] <= '0;
      end else begin
        // a new edge beats a clear in the same cycle
        req_ff[g] <= irq_rise[g] | (req_ff[g] & ~src_clr[g]);
        if (hit) lvl_ff[g] <= PWDATA[2:0];
      end
    end
  end

  // register read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    if (src_hit(PADDR)) begin
      rd_data[CTL_REQ] = req_ff[src_idx(PADDR)];
      rd_data[2:0] = lvl_ff[src_idx(PADDR)];
    end else begin
      case (PADDR)
        A_VBASE: rd_data[AW-1:0] = vector_base_reg_ff;
        A_FLAGS: rd_data[FLGW-1:0] = cpu_flags_reg_ff;
        A_IPL:   rd_data[2:0] = cpu_priority_level_ff;
        A_ISTK:  rd_data[AW-1:0] = irq_stack_ptr_ff;
        A_USTK:  rd_data[AW-1:0] = user_stack_ptr_ff;
        A_SVF:   rd_data[FLGW-1:0] = fast_flags_save_ff;
        A_SVPC:  rd_data[AW-1:0] = fast_pc_save_ff;
        A_STAT:  rd_data[12:0] = {state_ff, kind_ff, wdt_pend_ff,
                                  fast_ff, num_ff};
        A_FAST:  rd_data[3:0] = fast_ctl_ff;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // entry sequence and cpu state
  always_comb begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_num = num_ff;
    nxt_lvl_acc = lvl_acc_ff;
    nxt_fast = fast_ff;
    nxt_widx = widx_ff;
    nxt_pc = pc_ff;
    nxt_tmp_flags = tmp_flags_ff;
    nxt_vec = vec_ff;
    nxt_fast_flags_save = fast_flags_save_ff;
    nxt_fast_pc_save = fast_pc_save_ff;
    clr_req = 1'b0;
    nxt_cpu_flags_reg = cpu_flags_reg_ff;
    nxt_cpu_priority_level = cpu_priority_level_ff;
    nxt_vector_base_reg = vector_base_reg_ff;
    nxt_irq_stack_ptr = irq_stack_ptr_ff;
    nxt_user_stack_ptr = user_stack_ptr_ff;
    nxt_fast_ctl = fast_ctl_ff;
    if (apb_wr) begin
      case (PADDR)
        A_VBASE: nxt_vector_base_reg = PWDATA[AW-1:0];
        A_FLAGS: nxt_cpu_flags_reg = PWDATA[FLGW-1:0];
        A_IPL:   nxt_cpu_priority_level = PWDATA[2:0];
        A_ISTK:  nxt_irq_stack_ptr = PWDATA[AW-1:0];
        A_USTK:  nxt_user_stack_ptr = PWDATA[AW-1:0];
        A_FAST:  nxt_fast_ctl = PWDATA[3:0];
        default: ;
      endcase
    end
    // the sequencer overrides software in the same cycle
    unique case (state_ff)
      S_IDLE: if (take) begin
        nxt_kind = take_trap ? K_TRAP : (take_nmi ? K_NMI : K_MASK);
        nxt_num = take_trap ? TRAP_NUM
                            : SRC_NUM_BASE + {3'h0, win_i};
        nxt_lvl_acc = take_nmi ? NMI_LEVEL : win_l;
        nxt_fast = take_mask & is_fast;
        nxt_widx = win_i;
        nxt_pc = PROGRAM_COUNTER;
        nxt_state = take_mask ? S_INFO : S_SAVE;
      end
      S_INFO: if (mem_done) begin
        nxt_num = MEM_RDATA[5:0];
        nxt_lvl_acc = MEM_RDATA[INFO_LVL_LSB+2:INFO_LVL_LSB];
        clr_req = 1'b1;
        nxt_state = S_SAVE;
      end
      S_SAVE: begin
        nxt_tmp_flags = cpu_flags_reg_ff;
        nxt_cpu_flags_reg[F_I] = 1'b0;
        nxt_cpu_flags_reg[F_D] = 1'b0;
        if (!keep_u) nxt_cpu_flags_reg[F_U] = 1'b0;
        if (fast_ff) begin
          nxt_fast_flags_save = cpu_flags_reg_ff;
          nxt_fast_pc_save = pc_ff;
        end
        nxt_state = fast_ff ? S_VEC : S_PUSH_F;
      end
      S_PUSH_F, S_PUSH_PC: if (mem_done) begin
        if (cpu_flags_reg_ff[F_U])
          nxt_user_stack_ptr = sp_cur - 24'h00_0004;
        else
          nxt_irq_stack_ptr = sp_cur - 24'h00_0004;
        nxt_state = state_ff == S_PUSH_F ? S_PUSH_PC : S_VEC;
      end
      S_VEC: if (mem_done) begin
        nxt_vec = MEM_RDATA[AW-1:0];
        nxt_state = S_IPL;
      end
      S_IPL: begin
        // software traps leave the priority level alone
        if (kind_ff != K_TRAP) nxt_cpu_priority_level = lvl_acc_ff;
        nxt_state = S_GO;
      end
      S_GO: nxt_state = S_IDLE;
    endcase
  end

  // memory address and data per step
  always_comb begin
    mem_addr = INFO_ADDR;
    mem_wdata = 32'h0000_0000;
    unique case (state_ff)
      S_INFO: mem_addr = fast_ff ? FAST_INFO_ADDR : INFO_ADDR;
      S_PUSH_F: begin
        mem_addr = sp_cur - 24'h00_0004;
        mem_wdata[FLGW-1:0] = tmp_flags_ff;
      end
      S_PUSH_PC: begin
        mem_addr = sp_cur - 24'h00_0004;
        mem_wdata[AW-1:0] = pc_ff;
      end
      // the six-bit number keeps the read inside the table
      S_VEC: mem_addr = kind_ff == K_NMI ? WDT_VEC_ADDR
                                         : vec_addr;
      default: ;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      state_ff <= S_IDLE;
      kind_ff <= K_MASK;
      num_ff <= '0;
      lvl_acc_ff <= '0;
      fast_ff <= 1'b0;
      widx_ff <= '0;
      pc_ff <= '0;
      tmp_flags_ff <= FLAGS_RST;
      vec_ff <= '0;
      fast_flags_save_ff <= FLAGS_RST;
      fast_pc_save_ff <= STK_RST;
    end else begin
      state_ff <= nxt_state;
      kind_ff <= nxt_kind;
      num_ff <= nxt_num;
      lvl_acc_ff <= nxt_lvl_acc;
      fast_ff <= nxt_fast;
      widx_ff <= nxt_widx;
      pc_ff <= nxt_pc;
      tmp_flags_ff <= nxt_tmp_flags;
      vec_ff <= nxt_vec;
      fast_flags_save_ff <= nxt_fast_flags_save;
      fast_pc_save_ff <= nxt_fast_pc_save;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      cpu_flags_reg_ff <= FLAGS_RST;
      cpu_priority_level_ff <= '0;
      vector_base_reg_ff <= STK_RST;
      irq_stack_ptr_ff <= STK_RST;
      user_stack_ptr_ff <= STK_RST;
      fast_ctl_ff <= '0;
      wdt_pend_ff <= 1'b0;
      irq_prev_ff <= '0;
    end else begin
      cpu_flags_reg_ff <= nxt_cpu_flags_reg;
      cpu_priority_level_ff <= nxt_cpu_priority_level;
      vector_base_reg_ff <= nxt_vector_base_reg;
      irq_stack_ptr_ff <= nxt_irq_stack_ptr;
      user_stack_ptr_ff <= nxt_user_stack_ptr;
      fast_ctl_ff <= nxt_fast_ctl;
      wdt_pend_ff <= WDT_IN | (wdt_pend_ff & ~take_nmi);
      irq_prev_ff <= irq_s;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      MEM_REQ <= 1'b0;
      MEM_WE <= 1'b0;
      MEM_ADDR <= '0;
      MEM_WDATA <= 32'h0000_0000;
      ENTRY_BUSY <= 1'b0;
      SUSPEND <= 1'b0;
      FETCH_GO <= 1'b0;
      FETCH_ADDR <= '0;
    end else begin
      PREADY <= apb_set;
      PSLVERR <= apb_set & ~rd_ok;
      if (apb_set) PRDATA <= rd_data;
      MEM_REQ <= mem_need & ~mem_done;
      MEM_WE <= mem_we;
      MEM_ADDR <= mem_addr;
      MEM_WDATA <= mem_wdata;
      ENTRY_BUSY <= nxt_state != S_IDLE;
      SUSPEND <= take & ~take_trap & INSTR_BREAKABLE & ~INSTR_DONE;
      FETCH_GO <= state_ff == S_GO;
      FETCH_ADDR <= vec_ff;
    end
  end

  assign CPU_FLAGS = cpu_flags_reg_ff;
  assign CPU_IPL = cpu_priority_level_ff;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  chk_take_next: assert property (take |=> !idle)
    else $error("entry did not start after acceptance");
  chk_mask_gate: assert property ($rose(ENTRY_BUSY) && kind_ff == K_MASK
    |-> $past(cpu_flags_reg_ff[F_I]) &&
        $past(cpu_priority_level_ff) < lvl_acc_ff)
    else $error("maskable request taken while masked");
  chk_suspend_op: assert property (take && !take_trap && INSTR_BREAKABLE
    && !INSTR_DONE |=> SUSPEND &&
    state_ff == ($past(take_mask) ? S_INFO : S_SAVE))
    else $error("breakable op not suspended");
  chk_info_read: assert property (state_ff == S_INFO && MEM_REQ |->
    !MEM_WE && MEM_ADDR == (fast_ff ? FAST_INFO_ADDR : INFO_ADDR))
    else $error("wrong info fetch");
  chk_req_clear: assert property ($fell(req_ff[0]) |->
    $past(src_clr[0]) && !$past(irq_rise[0]))
    else $error("request bit dropped without clear");
  chk_flags_clear: assert property (state_ff == S_SAVE |=>
    !cpu_flags_reg_ff[F_I] && !cpu_flags_reg_ff[F_D] &&
    tmp_flags_ff == $past(cpu_flags_reg_ff))
    else $error("flags not captured or cleared");
  chk_fast_save: assert property (state_ff == S_SAVE && fast_ff |=>
    fast_pc_save_ff == $past(pc_ff) && state_ff == S_VEC)
    else $error("fast save skipped");
  chk_vec_window: assert property (state_ff == S_VEC && MEM_REQ &&
    kind_ff != K_NMI |-> MEM_ADDR == vec_addr &&
    MEM_ADDR - vector_base_reg_ff < 24'h00_0100)
    else $error("vector outside table");
  chk_ipl_last: assert property (state_ff == S_IPL && kind_ff != K_TRAP
    |=> cpu_priority_level_ff == $past(lvl_acc_ff) ##1 FETCH_GO
    && FETCH_ADDR == vec_ff)
    else $error("level or dispatch wrong");
  chk_trap_bypass: assert property (idle && TRAP_REQ |=>
    state_ff == S_SAVE && kind_ff == K_TRAP)
    else $error("trap not taken");

  cov_mask_entry: cover property (take_mask ##[1:40] FETCH_GO);
  cov_trap_entry: cover property (take_trap ##[1:40] FETCH_GO);
  cov_fast_entry: cover property (state_ff == S_SAVE && fast_ff);
  cov_suspend:    cover property (SUSPEND);
endmodule : ieu_top

// ==== tb/ieu_mem_model.sv ====
// memory responder on the far side of the memory port
module ieu_mem_model (
  // clock
  input  wire logic        clk,
  // request side
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [23:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [31:0] info,
  // answer side
  output logic             mem_ack,
  output logic      [31:0] mem_rdata,
  output logic      [23:0] last_a,
  output logic      [31:0] last_d
);
  timeunit 1ns;
  timeprecision 1ns;
  logic go;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0000_0000;
    last_a = 24'h00_0000;
    last_d = 32'h0000_0000;
  end
  // random stalls; stale data toggles so it never looks valid
  always @(posedge clk) begin
    go = ($urandom_range(2) == 0);
    if (mem_req && !mem_ack && go) begin
      mem_ack <= 1'b1;
      mem_rdata <= (mem_addr[23:2] == 0) ? info : {8'h00, ~mem_addr};
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
    if (mem_ack && mem_we) begin
      last_a <= mem_addr;
      last_d <= mem_wdata;
    end
  end
endmodule : ieu_mem_model

// ==== tb/tb_ieu_top.sv ====
// self-checking bench of the interrupt entry unit
module tb_ieu_top;
  import ieu_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, psel, penable, pwrite, wdt, done, brk, trap;
  logic [7:0] paddr, irq;
  logic [31:0] pwdata, rd, info, mrd, last_d, prdata;
  logic [5:0] tnum;
  logic [23:0] pc, vb, last_a, faddr, maddr;
  logic [2:0] lv, cpu_flags_reg, cpu_priority_level;
  logic er, sus, pready, pslverr, busy, susp, fgo, mreq, mwe, mack;
  logic [31:0] mwd;
  int fail_count, check_count, i, k, n;
  always #2 clk = ~clk;
  ieu_top u_dut (.CLK_SYS(clk), .RST_B(rst_b), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ_IN(irq),
    .WDT_IN(wdt), .INSTR_DONE(done), .INSTR_BREAKABLE(brk),
    .TRAP_REQ(trap), .TRAP_NUM(tnum), .PROGRAM_COUNTER(pc),
    .ENTRY_BUSY(busy), .SUSPEND(susp), .FETCH_GO(fgo), .FETCH_ADDR(faddr),
    .CPU_FLAGS(cpu_flags_reg), .CPU_IPL(cpu_priority_level), .MEM_REQ(mreq), .MEM_WE(mwe),
    .MEM_ADDR(maddr), .MEM_WDATA(mwd), .MEM_ACK(mack), .MEM_RDATA(mrd));
  ieu_mem_model u_mem (.clk(clk), .mem_req(mreq), .mem_we(mwe),
    .mem_addr(maddr), .mem_wdata(mwd), .info(info), .mem_ack(mack),
    .mem_rdata(mrd), .last_a(last_a), .last_d(last_d));
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 64);
    if (pready !== 1'b1) chk(t, 0);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // the memory model answers a vector read with the inverted address
  function automatic logic [31:0] exp_fetch(input logic [23:0] a);
    return {8'h00, ~a};
  endfunction : exp_fetch
  task automatic pulse_done;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  endtask : pulse_done
  // trap and breakable op drop as soon as the unit reacts
  task automatic wait_go;
    int t;
    t = 0;
    sus = 1'b0;
    while (fgo !== 1'b1 && t < 300) begin
      @(posedge clk);
      t++;
      if (busy === 1'b1) trap <= 1'b0;
      if (susp === 1'b1) begin
        sus = 1'b1;
        brk <= 1'b0;
      end
    end
    chk(t < 300, 1);
  endtask : wait_go
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
  initial begin
    {clk, rst_b, psel, penable, pwrite, wdt, done, brk, trap} = 0;
    {paddr, irq, pwdata, info, tnum, pc} = 0;
    void'($urandom(32'hebb7b41f));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(0, A_IPL, 0); chk(rd, 0);
    apb(0, A_FLAGS, 0); chk(rd, 0);
    apb(1, 8'hFC, 1); chk(er, 1);
    apb(0, 8'hFC, 0); chk(rd, 0);
    // table kept clear of the low register area and the top page
    vb = (24'($urandom) & 24'h7F_FFFC) | 24'h01_0000;
    apb(1, A_VBASE, {8'h00, vb}); apb(0, A_VBASE, 0); chk(rd, vb);
    // maskable entries, k==1 fast, odd k mid-op
    for (k = 0; k < 6; k++) begin
      i = $urandom_range(7);
      lv = 3'($urandom_range(7, 1));
      pc = 24'($urandom);
      apb(1, A_ISTK, 32'h0000_8000);
      apb(1, A_FLAGS, 32'h0000_0007);
      apb(1, A_IPL, 0);
      apb(1, A_FAST, (k == 1) ? 8 + i : 0);
      apb(1, A_SRC0 + 8'(4 * i), lv);
      info <= {21'h0, lv, 2'b00, 6'(8 + i)};
      irq[i] <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1, A_SRC0 + 8'(4 * i), 8 + lv);
      apb(0, A_SRC0 + 8'(4 * i), 0); chk(rd[3], 1);
      if (k % 2) brk <= 1'b1;
      else pulse_done();
      wait_go();
      irq[i] <= 1'b0;
      chk(faddr, exp_fetch(vb + 24'(4 * (8 + i))));
      chk(cpu_priority_level, lv);
      chk(cpu_flags_reg, 0);
      chk(sus, k % 2);
      if (k == 1) begin
        apb(0, A_SVPC, 0); chk(rd, pc);
        apb(0, A_SVF, 0);
        chk(rd, 7);
      end else begin
        chk(last_a, 24'h00_7FF8);
        chk(last_d, pc);
      end
      apb(0, A_SRC0 + 8'(4 * i), 0); chk(rd[3], 0);
    end
    apb(1, A_FAST, 0);
    // equal level, then enable off: both refused
    apb(1, A_FLAGS, 1); apb(1, A_IPL, 3); apb(1, A_SRC0, 3);
    irq[0] <= 1'b1;
    repeat (4) @(posedge clk);
    pulse_done(); repeat (10) @(posedge clk); chk(busy, 0);
    apb(1, A_IPL, 0); apb(1, A_FLAGS, 0);
    pulse_done(); repeat (10) @(posedge clk); chk(busy, 0);
    apb(1, A_SRC0, 3); apb(0, A_SRC0, 0); chk(rd[3], 0);
    irq[0] <= 1'b0;
    // two edges at once: higher level wins
    apb(1, A_FLAGS, 1); apb(1, A_SRC0 + 8, 2); apb(1, A_SRC0 + 20, 6);
    info <= {21'h0, 3'd6, 2'b00, 6'd13};
    irq <= 8'h24;
    repeat (4) @(posedge clk);
    pulse_done(); wait_go();
    chk(cpu_priority_level, 6);
    apb(0, A_SRC0 + 20, 0); chk(rd[3], 0);
    apb(0, A_SRC0 + 8, 0); chk(rd[3], 1);
    apb(1, A_SRC0 + 8, 2); irq <= 0;
    // equal levels: the earlier edge beats the index order
    apb(1, A_IPL, 0);
    apb(1, A_SRC0 + 4, 4);
    apb(1, A_SRC0 + 24, 4);
    info <= {21'h0, 3'd4, 2'b00, 6'd14};
    irq[6] <= 1'b1;
    repeat (4) @(posedge clk);
    irq[1] <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1, A_FLAGS, 1);
    pulse_done();
    wait_go();
    apb(0, A_SRC0 + 24, 0);
    chk(rd[3], 0);
    apb(0, A_SRC0 + 4, 0);
    chk(rd[3], 1);
    apb(1, A_SRC0 + 4, 4);
    irq <= 0;
    // watchdog ignores masking
    apb(1, A_FLAGS, 0);
    wdt <= 1'b1; @(posedge clk); wdt <= 1'b0;
    pulse_done(); wait_go();
    chk(faddr, exp_fetch(WDT_VEC_ADDR));
    chk(cpu_priority_level, NMI_LEVEL);
    // traps with enable off and level 7
    for (k = 0; k < 4; k++) begin
      n = (k < 2) ? 31 + k : $urandom_range(63);
      apb(1, A_FLAGS, 4);
      trap <= 1'b1;
      tnum <= 6'(n);
      wait_go();
      chk(faddr, exp_fetch(vb + 24'(4 * n)));
      chk(cpu_flags_reg, (n >= 32) ? 4 : 0);
      chk(cpu_priority_level, NMI_LEVEL);
    end
    report_and_stop();
  end
endmodule : tb_ieu_top
